// ### pkg/wde_defs.svh
// Register offsets, field positions, reset values and timing counts of the waveform extension.
`ifndef WDE_DEFS_SVH
`define WDE_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the APB slave
// ----------------------------------------------------------------------------
`define WDE_OFS_CTRL     8'h00
`define WDE_OFS_FAULT    8'h04
`define WDE_OFS_STATUS   8'h08
`define WDE_OFS_MASK     8'h0C
`define WDE_OFS_DT_LOW   8'h10
`define WDE_OFS_DT_HIGH  8'h14
`define WDE_OFS_OVERRIDE 8'h18
`define WDE_OFS_PATTERN  8'h1C
`define WDE_OFS_STATE    8'h20

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define WDE_ST_FAULT     0
`define WDE_ST_UPDATE    1
`define WDE_PEND_DT_LOW  0
`define WDE_PEND_DT_HIGH 1
`define WDE_PEND_PATTERN 2

// ----------------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------------
`define WDE_RST_CTRL     7'h00
`define WDE_RST_FAULT    9'h000
`define WDE_RST_BYTE     8'h00
`define WDE_RST_FLAGS    2'h0
`define WDE_RST_PEND     3'h0
`define WDE_DT_ZERO      8'h00
`define WDE_DT_ONE       8'h01

`endif

// ### pkg/wde_pkg.sv
// Types shared by the waveform extension modules.
`default_nettype none
package wde_pkg;

	// Dead-time unit states, Gray coded around the switching cycle.
	typedef enum logic [1:0] {
		st_low_on       = 2'h0,
		st_dead_to_high = 2'h1,
		st_high_on      = 2'h3,
		st_dead_to_low  = 2'h2
	} wde_dt_state_e;

	// Control register layout, bit 6 down to bit 0.
	typedef struct packed {
		logic       halt_en;
		logic       pattern_en;
		logic       chan_a_all;
		logic [3:0] unit_en;
	} wde_ctrl_s;

	// Fault configuration layout, bit 8 down to bit 0.
	typedef struct packed {
		logic       force_low;
		logic [7:0] ev_sel;
	} wde_fault_cfg_s;

	// Dead-time lengths in clock cycles for the two turn-on edges.
	typedef struct packed {
		logic [7:0] low_side;
		logic [7:0] high_side;
	} wde_dead_time_s;

	// One complementary output pair and its dead-interval marker.
	typedef struct packed {
		logic low_side;
		logic high_side;
		logic dead;
	} wde_pair_s;

endpackage : wde_pkg
`default_nettype wire

// ### hdl/wde_dead_time_unit.sv
// Dead-time unit: one waveform bit into a complementary pair with dead intervals.
`timescale 1ns/10ps
`default_nettype none
`include "wde_defs.svh"
module wde_dead_time_unit
	import wde_pkg::*;
(
	// Clock and reset.
	input  wire logic           clk,
	input  wire logic           rst_n,
	// Waveform bit and active dead-time lengths.
	input  wire logic           wave,
	input  wire wde_dead_time_s dt,
	// Complementary pair.
	output wde_pair_s           pair
);

	wde_dt_state_e state_ff;
	wde_dt_state_e nxt_state;
	logic [7:0]    cnt_ff;
	logic [7:0]    nxt_cnt;

	// A dead interval lasts the programmed number of cycles with both sides off.
	// A waveform that returns before the interval ends restores the side that was on.
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		case (state_ff)
			st_low_on: begin
				if (!wave) begin
					nxt_state = (dt.high_side == `WDE_DT_ZERO) ? st_high_on : st_dead_to_high;
					nxt_cnt   = dt.high_side;
				end
			end
			st_dead_to_high: begin
				if (wave) begin
					nxt_state = st_low_on;
				end else if (cnt_ff <= `WDE_DT_ONE) begin
					nxt_state = st_high_on;
				end else begin
					nxt_cnt = cnt_ff - `WDE_DT_ONE;
				end
			end
			st_high_on: begin
				if (wave) begin
					nxt_state = (dt.low_side == `WDE_DT_ZERO) ? st_low_on : st_dead_to_low;
					nxt_cnt   = dt.low_side;
				end
			end
			st_dead_to_low: begin
				if (!wave) begin
					nxt_state = st_high_on;
				end else if (cnt_ff <= `WDE_DT_ONE) begin
					nxt_state = st_low_on;
				end else begin
					nxt_cnt = cnt_ff - `WDE_DT_ONE;
				end
			end
			default: begin
				nxt_state = st_dead_to_low;
				nxt_cnt   = `WDE_DT_ZERO;
			end
		endcase
	end

	// State and interval counter.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff <= st_dead_to_low;
			cnt_ff   <= `WDE_DT_ZERO;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
		end
	end

	// Low side follows the waveform, high side its inverse, both off while dead.
	assign pair.low_side  = (state_ff == st_low_on);
	assign pair.high_side = (state_ff == st_high_on);
	assign pair.dead      = (state_ff == st_dead_to_high) || (state_ff == st_dead_to_low);

endmodule : wde_dead_time_unit
`default_nettype wire

// ### hdl/wde_fault_unit.sv
// Fault unit: selected events latch a fault flag that software clears.
`timescale 1ns/10ps
`default_nettype none
module wde_fault_unit
	import wde_pkg::*;
(
	// Clock and reset.
	input  wire logic           clk,
	input  wire logic           rst_n,
	// Event inputs and configuration.
	input  wire logic [7:0]     ev_in,
	input  wire wde_fault_cfg_s cfg,
	// Software clear and fault state.
	input  wire logic           clear,
	output logic                flag,
	output logic                fault_now
);

	logic flag_ff;
	wire  logic hit = |(ev_in & cfg.ev_sel);

	// A new event wins over a clear in the same cycle so no fault is lost.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flag_ff <= 1'b0;
		end else begin
			flag_ff <= hit | (flag_ff & ~clear);
		end
	end

	// The live hit is passed on so outputs go safe at the very next edge.
	assign flag      = flag_ff;
	assign fault_now = hit | flag_ff;

endmodule : wde_fault_unit
`default_nettype wire

// ### hdl/wde_waveform_extension.sv
// Waveform extension top: APB registers, dead-time units, pattern and port override.
//
// Notes on behaviour
// - With any extension feature on, each timer waveform bit becomes a complementary pin pair.
// - Four dead-time units exist, one per compare channel, with 8-bit dead-time lengths.
// - Low side carries the waveform, high side its inverse, with a dead gap at each switch.
// - The low-side turn-on edge and the high-side turn-on edge have their own dead-time length.
// - Dead-time values written by software take effect only at the timer update point.
// - When enabled, the timer is told to halt while any dead interval is in progress.
// - Pins selected by the override mask show the extension output instead of the port value.
// - The pattern is double-buffered and lands on all selected pins in one clock edge.
// - Optionally channel A's waveform is spread over every pin of the port.
// - While the pattern generator is on, the dead-time units are bypassed.
// - Any selected event triggers a fault that at once puts the outputs in a known state.
// - The waveform inputs come only from the compare channels of port C's timer zero.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "wde_defs.svh"
module wde_waveform_extension
	import wde_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Timer side.
	input  wire logic [3:0]  tc_wave,
	input  wire logic        tc_update,
	output logic             tc_halt,
	// Event system.
	input  wire logic [7:0]  ev_in,
	// Port side.
	input  wire logic [7:0]  port_in,
	output logic [7:0]       pin_out,
	// Interrupt.
	output logic             irq
);

	// ------------------------------------------------------------------------
	// Address decode helper
	// ------------------------------------------------------------------------

	// Exact byte-address compare, so a misaligned address never hits a register.
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction : hit

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------

	// Bus answer registers.
	logic           pready_ff;
	logic [31:0]    prdata_ff;
	logic           pslverr_ff;

	// Software-visible configuration.
	wde_ctrl_s      ctrl_ff;
	wde_fault_cfg_s fault_cfg_ff;
	logic [1:0]     mask_ff;
	logic [7:0]     override_ff;

	// Double buffers and their active copies.
	logic [7:0]     dt_low_buf_ff;
	logic [7:0]     dt_high_buf_ff;
	logic [7:0]     pattern_buf_ff;
	logic [2:0]     pend_ff;
	logic [2:0]     nxt_pend;
	wde_dead_time_s dt_act_ff;
	logic [7:0]     pattern_act_ff;

	// Sticky update flag and registered outputs.
	logic           upd_flag_ff;
	logic           irq_ff;
	logic           tc_halt_ff;
	logic [7:0]     pin_ff;

	// Per-unit pairs and derived vectors.
	wde_pair_s      pair [4];
	logic [7:0]     split_src;
	logic [3:0]     dead_vec;
	logic           fault_flag;
	logic           fault_now;

	// ------------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------------

	// The slave answers in the first access cycle; read data and error are latched in setup.
	wire logic setup_phase = psel & ~penable;
	wire logic access_done = psel & penable & pready_ff;
	wire logic wr_en       = access_done & pwrite;

	// Register select lines.
	wire logic sel_ctrl     = hit(paddr, `WDE_OFS_CTRL);
	wire logic sel_fault    = hit(paddr, `WDE_OFS_FAULT);
	wire logic sel_status   = hit(paddr, `WDE_OFS_STATUS);
	wire logic sel_mask     = hit(paddr, `WDE_OFS_MASK);
	wire logic sel_dt_low   = hit(paddr, `WDE_OFS_DT_LOW);
	wire logic sel_dt_high  = hit(paddr, `WDE_OFS_DT_HIGH);
	wire logic sel_override = hit(paddr, `WDE_OFS_OVERRIDE);
	wire logic sel_pattern  = hit(paddr, `WDE_OFS_PATTERN);
	wire logic sel_state    = hit(paddr, `WDE_OFS_STATE);
	wire logic map_ok       = sel_ctrl | sel_fault | sel_status | sel_mask | sel_dt_low
	                        | sel_dt_high | sel_override | sel_pattern | sel_state;

	// Write strobes, one per register except the read-only state register.
	wire logic wr_ctrl     = wr_en & sel_ctrl;
	wire logic wr_fault    = wr_en & sel_fault;
	wire logic wr_status   = wr_en & sel_status;
	wire logic wr_mask     = wr_en & sel_mask;
	wire logic wr_dt_low   = wr_en & sel_dt_low;
	wire logic wr_dt_high  = wr_en & sel_dt_high;
	wire logic wr_override = wr_en & sel_override;
	wire logic wr_pattern  = wr_en & sel_pattern;

	// Write-one-to-clear requests for the two sticky status bits.
	wire logic clr_fault = wr_status & pwdata[`WDE_ST_FAULT];
	wire logic clr_upd   = wr_status & pwdata[`WDE_ST_UPDATE];

	// Read multiplexer; unmapped addresses read zero and raise pslverr.
	wire logic [31:0] rd_word =
		sel_ctrl     ? {25'h0, ctrl_ff} :
		sel_fault    ? {23'h0, fault_cfg_ff} :
		sel_status   ? {30'h0, upd_flag_ff, fault_flag} :
		sel_mask     ? {30'h0, mask_ff} :
		sel_dt_low   ? {24'h000000, dt_low_buf_ff} :
		sel_dt_high  ? {24'h000000, dt_high_buf_ff} :
		sel_override ? {24'h000000, override_ff} :
		sel_pattern  ? {24'h000000, pattern_buf_ff} :
		sel_state    ? {21'h0, pend_ff, pin_ff} :
		32'h00000000;

	// Bus answer: pready for one cycle after each setup cycle.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff  <= setup_phase;
			prdata_ff  <= setup_phase ? rd_word : prdata_ff;
			pslverr_ff <= setup_phase & ~map_ok;
		end
	end

	// ------------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------------

	// Plain read-write configuration; these take effect at once.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_ff      <= `WDE_RST_CTRL;
			fault_cfg_ff <= `WDE_RST_FAULT;
			mask_ff      <= `WDE_RST_FLAGS;
			override_ff  <= `WDE_RST_BYTE;
		end else begin
			ctrl_ff      <= wr_ctrl ? pwdata[6:0] : ctrl_ff;
			fault_cfg_ff <= wr_fault ? pwdata[8:0] : fault_cfg_ff;
			mask_ff      <= wr_mask ? pwdata[1:0] : mask_ff;
			override_ff  <= wr_override ? pwdata[7:0] : override_ff;
		end
	end

	// ------------------------------------------------------------------------
	// Double buffers
	// ------------------------------------------------------------------------

	// A pending bit marks a buffer newer than its active copy. A write in the
	// same cycle as the update keeps the bit set, so that value waits for the
	// next update instead of being lost.
	assign nxt_pend[`WDE_PEND_DT_LOW]  = wr_dt_low  | (pend_ff[`WDE_PEND_DT_LOW]  & ~tc_update);
	assign nxt_pend[`WDE_PEND_DT_HIGH] = wr_dt_high | (pend_ff[`WDE_PEND_DT_HIGH] & ~tc_update);
	assign nxt_pend[`WDE_PEND_PATTERN] = wr_pattern | (pend_ff[`WDE_PEND_PATTERN] & ~tc_update);

	// An update point with anything pending is the event reported in status.
	wire logic upd_event = tc_update & (|pend_ff);

	// Buffer side, written by software only.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dt_low_buf_ff  <= `WDE_RST_BYTE;
			dt_high_buf_ff <= `WDE_RST_BYTE;
			pattern_buf_ff <= `WDE_RST_BYTE;
			pend_ff        <= `WDE_RST_PEND;
		end else begin
			dt_low_buf_ff  <= wr_dt_low ? pwdata[7:0] : dt_low_buf_ff;
			dt_high_buf_ff <= wr_dt_high ? pwdata[7:0] : dt_high_buf_ff;
			pattern_buf_ff <= wr_pattern ? pwdata[7:0] : pattern_buf_ff;
			pend_ff        <= nxt_pend;
		end
	end

	// Active side, loaded only at the timer update point, never mid-period.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dt_act_ff      <= {`WDE_RST_BYTE, `WDE_RST_BYTE};
			pattern_act_ff <= `WDE_RST_BYTE;
		end else if (tc_update) begin
			dt_act_ff      <= {dt_low_buf_ff, dt_high_buf_ff};
			pattern_act_ff <= pattern_buf_ff;
		end
	end

	// ------------------------------------------------------------------------
	// Dead-time units
	// ------------------------------------------------------------------------

	// One unit per compare channel of port C's timer zero. A channel whose unit
	// is off is still split into a pair, only without dead time.
	for (genvar i = 0; i < 4; i++) begin : g_unit
		wde_dead_time_unit u_unit (
			.clk   (clk),
			.rst_n (rst_n),
			.wave  (tc_wave[i]),
			.dt    (dt_act_ff),
			.pair  (pair[i])
		);
		assign split_src[2*i]   = ctrl_ff.unit_en[i] ? pair[i].low_side  : tc_wave[i];
		assign split_src[2*i+1] = ctrl_ff.unit_en[i] ? pair[i].high_side : ~tc_wave[i];
		assign dead_vec[i]      = ctrl_ff.unit_en[i] & pair[i].dead;
	end

	// ------------------------------------------------------------------------
	// Fault unit
	// ------------------------------------------------------------------------

	// The fault flag doubles as status bit zero; writing it one clears it.
	wde_fault_unit u_fault (
		.clk       (clk),
		.rst_n     (rst_n),
		.ev_in     (ev_in),
		.cfg       (fault_cfg_ff),
		.clear     (clr_fault),
		.flag      (fault_flag),
		.fault_now (fault_now)
	);

	// ------------------------------------------------------------------------
	// Output selection
	// ------------------------------------------------------------------------

	// Any feature switched on hands the selected pins to the extension.
	wire logic any_feat = (|ctrl_ff.unit_en) | ctrl_ff.chan_a_all | ctrl_ff.pattern_en;

	// Channel A pair repeated over all four pin pairs.
	wire logic [7:0] spread_src = {4{split_src[1:0]}};

	// Pattern bits go straight to the pins; with channel A spreading on, a set
	// pattern bit carries channel A's raw waveform instead of a constant one.
	wire logic [7:0] pattern_src = ctrl_ff.chan_a_all ? (pattern_act_ff & {8{tc_wave[0]}})
	                                                  : pattern_act_ff;

	// The pattern generator bypasses the dead-time units entirely.
	wire logic [7:0] wave_src = ctrl_ff.pattern_en ? pattern_src :
	                            ctrl_ff.chan_a_all ? spread_src  :
	                            split_src;

	// Pins owned by the extension.
	wire logic [7:0] own_pins = {8{any_feat}} & override_ff;

	// Fault state: release the pins to the port value, or force them low. Forcing
	// low is the safe choice for drivers whose off state is a low input.
	wire logic [7:0] fault_val = fault_cfg_ff.force_low ? 8'h00 : port_in;
	wire logic [7:0] ext_val   = fault_now ? fault_val : wave_src;

	// Final pin value, merged with the normal port output.
	wire logic [7:0] nxt_pin = (own_pins & ext_val) | (~own_pins & port_in);

	// Halt request while a dead interval runs; no unit is in use in pattern mode.
	wire logic nxt_halt = ctrl_ff.halt_en & ~ctrl_ff.pattern_en & (|dead_vec);

	// All pins switch on the same edge, so a new pattern lands at once.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_ff     <= `WDE_RST_BYTE;
			tc_halt_ff <= 1'b0;
		end else begin
			pin_ff     <= nxt_pin;
			tc_halt_ff <= nxt_halt;
		end
	end

	// ------------------------------------------------------------------------
	// Interrupt
	// ------------------------------------------------------------------------

	// Update flag is sticky; a new event beats a clear in the same cycle.
	wire logic nxt_upd = upd_event | (upd_flag_ff & ~clr_upd);

	// The interrupt level is registered; it rises with the update flag but one cycle after the fault flag.
	wire logic nxt_irq = |({nxt_upd, fault_flag} & mask_ff);

	// Status and interrupt registers.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			upd_flag_ff <= 1'b0;
			irq_ff      <= 1'b0;
		end else begin
			upd_flag_ff <= nxt_upd;
			irq_ff      <= nxt_irq;
		end
	end

	// ------------------------------------------------------------------------
	// Output ports
	// ------------------------------------------------------------------------

	// Every output port comes straight from a register.
	assign pready  = pready_ff;
	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff;
	assign tc_halt = tc_halt_ff;
	assign pin_out = pin_ff;
	assign irq     = irq_ff;

endmodule : wde_waveform_extension
`default_nettype wire

// ### testbench/wde_waveform_extension_chk.sv
// Port-level assertion checker for the waveform extension.
`timescale 1ns/10ps
`default_nettype none
`include "wde_defs.svh"
module wde_waveform_extension_chk (
	// Clock and reset.
	input wire logic        clk,
	input wire logic        rst_n,
	// APB slave.
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Timer, events, port and interrupt.
	input wire logic [3:0]  tc_wave,
	input wire logic        tc_update,
	input wire logic        tc_halt,
	input wire logic [7:0]  ev_in,
	input wire logic [7:0]  port_in,
	input wire logic [7:0]  pin_out,
	input wire logic        irq
);
	// ------------------------------------------------------------------------
	// Shadow of the configuration seen on the bus
	// ------------------------------------------------------------------------
	logic [6:0] ctrl_ff;
	logic [8:0] fcfg_ff;
	logic [7:0] ovr_ff, pbuf_ff, pact_ff;
	logic       msk_ff, flt_ff;

	// Decodes of the shadow; ownership only exists while a feature is on.
	wire       wr_w   = psel & penable & pready & pwrite;
	wire       anyf_w = |ctrl_ff[5:0];
	wire [7:0] own_w  = anyf_w ? ovr_ff : 8'h00;
	wire       trip_w = |(ev_in & fcfg_ff[7:0]);
	wire       hit_w  = flt_ff | trip_w;
	wire       clr_w  = wr_w && paddr == `WDE_OFS_STATUS && pwdata[0];
	wire       wa_w   = tc_wave[0];

	// Set wins over clear, so a trip during a clear write keeps the flag.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{ctrl_ff, fcfg_ff, ovr_ff, pbuf_ff, pact_ff, msk_ff, flt_ff} <= '0;
		end else begin
			if (wr_w && paddr == `WDE_OFS_CTRL) ctrl_ff <= pwdata[6:0];
			if (wr_w && paddr == `WDE_OFS_FAULT) fcfg_ff <= pwdata[8:0];
			if (wr_w && paddr == `WDE_OFS_OVERRIDE) ovr_ff <= pwdata[7:0];
			if (wr_w && paddr == `WDE_OFS_PATTERN) pbuf_ff <= pwdata[7:0];
			if (wr_w && paddr == `WDE_OFS_MASK) msk_ff <= pwdata[0];
			if (tc_update) pact_ff <= pbuf_ff;
			flt_ff <= trip_w | (flt_ff & ~clr_w);
		end
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_ready_after_setup: assert property (psel && !penable |=> pready && !$past(pready))
		else $error("Ready not given in the first access cycle.");
	a_err_unmapped: assert property (pready && (paddr > 8'h20 || paddr[1:0] != 2'h0) |-> pslverr)
		else $error("Unmapped access not refused.");
	a_port_passthru: assert property ($past(rst_n) |->
		((pin_out ^ $past(port_in)) & ~$past(own_w)) == 8'h00)
		else $error("Pin not owned differs from port value.");
	a_fault_safe: assert property ($past(rst_n && hit_w && fcfg_ff[8]) |->
		(pin_out & $past(own_w)) == 8'h00) else $error("Owned pin high during fault.");
	a_fault_irq: assert property (flt_ff && msk_ff |=> irq)
		else $error("Held fault without interrupt.");
	a_no_overlap: assert property ($past(rst_n && anyf_w && !ctrl_ff[5] && !hit_w) |->
		(pin_out & (pin_out >> 1) & $past(ovr_ff & (ovr_ff >> 1)) & 8'h55) == 8'h00)
		else $error("Both sides of a pair on.");
	a_halt_gate: assert property ($past(!ctrl_ff[6] || ctrl_ff[5]) |-> !tc_halt)
		else $error("Timer halted while halting is off.");
	a_pattern_lands: assert property ($past(rst_n && ctrl_ff[5] && !ctrl_ff[4] && !hit_w) |->
		((pin_out ^ $past(pact_ff)) & $past(ovr_ff)) == 8'h00)
		else $error("Pins differ from active pattern.");
	a_chan_a_spread: assert property ($past(rst_n && ctrl_ff[5:0] == 6'h10 && !hit_w) |->
		((pin_out ^ {4{~$past(wa_w), $past(wa_w)}}) & $past(ovr_ff)) == 8'h00)
		else $error("Channel A not spread over the pins.");
endmodule : wde_waveform_extension_chk
`default_nettype wire

// ### testbench/wde_power_driver.sv
// Model of the external half-bridge drivers fed by the pin pairs.
`timescale 1ns/10ps
`default_nettype none
module wde_power_driver (
	// Clock and reset.
	input wire logic   clk,
	input wire logic   rst_n,
	// Pins and guard enable.
	input wire logic       armed,
	input wire logic [7:0] pin_out,
	// Shoot-through cycles seen.
	output logic [15:0]    shoot_cnt
);
	// A leg conducts through when both its switches are on at once.
	wire [3:0] cross_w = pin_out[0 +: 8] == 8'h00 ? 4'h0 :
		{pin_out[7] & pin_out[6], pin_out[5] & pin_out[4], pin_out[3] & pin_out[2],
		 pin_out[1] & pin_out[0]};

	// Only counted while the bench drives real half-bridges, not a pattern.
	always_ff @(posedge clk) begin
		if (!rst_n) shoot_cnt <= 16'h0000;
		else if (armed && |cross_w) shoot_cnt <= shoot_cnt + 16'h0001;
	end
endmodule : wde_power_driver
`default_nettype wire

// ### testbench/test_wde_waveform_extension.sv
// Self-checking bench for the waveform extension over APB.
`timescale 1ns/10ps
`default_nettype none
module test_wde_waveform_extension;
	// ------------------------------------------------------------------------
	// Signals, clock and instances
	// ------------------------------------------------------------------------
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, tc_update, tc_halt, irq;
	logic        armed, e;
	logic [7:0]  paddr, ev_in, port_in, pin_out;
	logic [31:0] pwdata, prdata, r;
	logic [3:0]  tc_wave;
	logic [15:0] shoot_cnt;
	int          err_total, total_checks, n, h;

	always #4 clk = ~clk;

	wde_waveform_extension uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .tc_wave(tc_wave), .tc_update(tc_update), .tc_halt(tc_halt),
		.ev_in(ev_in), .port_in(port_in), .pin_out(pin_out), .irq(irq));
	wde_power_driver drv (.clk(clk), .rst_n(rst_n), .armed(armed), .pin_out(pin_out),
		.shoot_cnt(shoot_cnt));

	// ------------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic give_verdict;
		if (err_total == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict

	// One APB transfer; entered just after an edge, leaves one idle edge behind.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// Only the watchdog ends a wait for a slave that never answers.
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(r, exp);
	endtask : rd

	task automatic upd;
		tc_update <= 1'b1;
		@(posedge clk);
		tc_update <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : upd

	// Steps the waveform and counts dead and halted samples until the pins settle.
	task automatic gap(input logic [3:0] w, input logic [7:0] fin);
		int k;
		n = 0;
		h = 0;
		tc_wave <= w;
		for (k = 0; k < 40; k++) begin
			@(posedge clk);
			if (pin_out === fin) break;
			n += (pin_out === 8'h00);
			h += (tc_halt === 1'b1);
		end
		chk(pin_out, fin);
	endtask : gap

	// ------------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------------
	initial begin
		{clk, rst_n, psel, penable, pwrite, tc_update, armed, e} = '0;
		{paddr, ev_in, port_in, pwdata, r, tc_wave, err_total, total_checks} = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'h0000_0000);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		chk(e, 1'b1);
		port_in <= 8'hA5;
		repeat (2) @(posedge clk);
		chk(pin_out, 8'hA5);
		apb(1'b1, 8'h18, 32'hFF);
		apb(1'b1, 8'h10, 32'h03);
		apb(1'b1, 8'h14, 32'h05);
		upd();
		apb(1'b1, 8'h00, 32'h4F);
		armed <= 1'b1;
		gap(4'h0, 8'hAA);
		gap(4'hF, 8'h55);
		chk(n, 3);
		chk(h, 3);
		gap(4'h0, 8'hAA);
		chk(n, 5);
		apb(1'b1, 8'h10, 32'h00);
		rd(8'h20, 32'h1AA);
		gap(4'hF, 8'h55);
		chk(n, 3);
		upd();
		gap(4'h0, 8'hAA);
		gap(4'hF, 8'h55);
		chk(n, 0);
		apb(1'b1, 8'h00, 32'h0F);
		gap(4'h0, 8'hAA);
		chk(h, 0);
		armed <= 1'b0;
		apb(1'b1, 8'h18, 32'h0F);
		apb(1'b1, 8'h1C, 32'h3C);
		rd(8'h20, 32'h4AA);
		apb(1'b1, 8'h00, 32'h2F);
		repeat (2) @(posedge clk);
		chk(pin_out, 8'hA0);
		upd();
		chk(pin_out, 8'hAC);
		rd(8'h08, 32'h2);
		apb(1'b1, 8'h08, 32'h2);
		rd(8'h08, 32'h0);
		apb(1'b1, 8'h18, 32'hFF);
		apb(1'b1, 8'h00, 32'h10);
		armed <= 1'b1;
		tc_wave <= 4'h1;
		repeat (2) @(posedge clk);
		chk(pin_out, 8'h55);
		tc_wave <= 4'hE;
		repeat (2) @(posedge clk);
		chk(pin_out, 8'hAA);
		apb(1'b1, 8'h0C, 32'h1);
		for (int f = 0; f < 2; f++) begin
			apb(1'b1, 8'h04, f ? 32'h004 : 32'h104);
			ev_in <= 8'h01;
			repeat (2) @(posedge clk);
			chk(pin_out, 8'hAA);
			ev_in <= 8'h04;
			@(posedge clk);
			ev_in <= 8'h00;
			repeat (5) @(posedge clk);
			chk(pin_out, f ? 8'hA5 : 8'h00);
			chk(irq, 1'b1);
			rd(8'h08, 32'h1);
			apb(1'b1, 8'h08, 32'h1);
			repeat (2) @(posedge clk);
			chk({irq, pin_out}, 9'h0AA);
		end
		chk(shoot_cnt, 16'h0000);
		give_verdict();
	end

	initial begin
		#100000;
		err_total++;
		give_verdict();
	end
endmodule : test_wde_waveform_extension

bind wde_waveform_extension wde_waveform_extension_chk chk_i (.clk(clk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .tc_wave(tc_wave), .tc_update(tc_update),
	.tc_halt(tc_halt), .ev_in(ev_in), .port_in(port_in), .pin_out(pin_out), .irq(irq));
`default_nettype wire
